// file: rtl/backplane_collision_map.vh
// Constants for the 10 Mbps backplane collision signalling block.
// Assumes a 200 MHz core clock and an 80..100 ns backplane recovered clock.
`ifndef BACKPLANE_COLLISION_MAP_VH
`define BACKPLANE_COLLISION_MAP_VH

// Board lead select value that marks the lead device
`define LEAD_SELECT_VALUE 1'b0
// Reset value of released open-drain lines (enable_n high = released)
`define OE_N_RELEASED 1'b1
// Reset value of the hold-collision output
`define HOLD_RESET 1'b0
// Idle level of the shared serial data line
`define DATA_IDLE 1'b1
// Cycles to wait for MAC carrier after the participate pulse: 400 ns at 5 ns a cycle.
// Sized to the window counter so the load neither pads nor drops bits.
`define PART_WINDOW_CYC 8'h50

`endif

// file: rtl/backplane_collision.v
// Collision signalling of the 10 Mbps inter-repeater backplane.
// Assumes the repeater core supplies collision events on ref_clk_i; pins are
// open drain except hold, which is push-pull; resolved by the bench from the output enables (low = driving).
`timescale 1ns/1ps
`include "backplane_collision_map.vh"

module backplane_collision (
   input  wire ref_clk_i,
   input  wire rst_b_i,
   input  wire seg_collision_i,
   input  wire tx_collision_i,
   input  wire nonlocal_tx_collision_i,
   input  wire board_lead_select_i,
   input  wire ext_mac_participate_i,
   input  wire ext_mac_tx_collision_i,
   input  wire core_carrier_i,
   input  wire core_tx_data_i,
   input  wire local_collision_n_i,
   output reg  local_collision_n_o,
   output reg  local_collision_n_oe_n_o,
   output reg  backplane_collision_n_o,
   output reg  backplane_collision_n_oe_n_o,
   input  wire collision_force_sense_i,
   output reg  collision_force_sense_o,
   output reg  collision_force_sense_oe_n_o,
   output reg  backplane_force_sense_o,
   output reg  backplane_force_sense_oe_n_o,
   output reg  hold_collision_extend_o,
   output reg  hold_collision_extend_oe_n_o,
   input  wire backplane_carrier_n_i,
   output reg  backplane_carrier_n_o,
   output reg  backplane_carrier_n_oe_n_o,
   input  wire backplane_recovered_clock_i,
   input  wire backplane_serial_data_i,
   output reg  backplane_serial_data_o,
   output reg  backplane_serial_data_oe_n_o,
   output reg  rx_data_o,
   output reg  rx_data_valid_o,
   output reg  mac_joined_o,
   output reg  far_collision_o
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_ARMED = 2'b01;
   localparam [1:0] ST_JOINED = 2'b10;

   // Reset release through two flops so all logic leaves reset together
   reg rst_s1_r;
   reg rst_n_r;
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Two-flop synchronisers for the backplane, shared collision and strap inputs; the external MAC pins are used unsynchronised
   localparam integer NSYNC = 6;
   wire [NSYNC-1:0] async_in;
   reg  [NSYNC-1:0] sync1_r;
   reg  [NSYNC-1:0] sync2_r;
   assign async_in = {backplane_recovered_clock_i, backplane_serial_data_i, backplane_carrier_n_i,
                      local_collision_n_i, board_lead_select_i, collision_force_sense_i};
   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1) begin : gen_sync
         always @(posedge ref_clk_i or negedge rst_n_r) begin
            if (!rst_n_r) begin
               sync1_r[g] <= 1'b1;
               sync2_r[g] <= 1'b1;
            end else begin
               sync1_r[g] <= async_in[g];
               sync2_r[g] <= sync1_r[g];
            end
         end
      end
   endgenerate

   wire rclk_s    = sync2_r[5];
   wire rdata_s   = sync2_r[4];
   wire carrier_s = sync2_r[3];
   wire lcol_s    = sync2_r[2];
   wire lead_s    = sync2_r[1];
   wire cfs_s     = sync2_r[0];

   // Edge finder on the sampled recovered clock; it may stop between frames
   reg rclk_d_r;
   wire rclk_rise = rclk_s & ~rclk_d_r;

   // External MAC join sequence: participate pulse, then carrier low
   reg [1:0] mac_st_r;
   reg [1:0] mac_st_nxt;
   reg [7:0] win_cnt_r;
   always @* begin
      mac_st_nxt = mac_st_r;
      case (mac_st_r)
         ST_IDLE: begin
            if (ext_mac_participate_i)
               mac_st_nxt = ST_ARMED;
         end
         ST_ARMED: begin
            if (!carrier_s && !core_carrier_i)
               mac_st_nxt = ST_JOINED;
            else if (win_cnt_r == 8'h00)
               mac_st_nxt = ST_IDLE;
         end
         ST_JOINED: begin
            if (carrier_s)
               mac_st_nxt = ST_IDLE;
         end
         default: mac_st_nxt = ST_IDLE;
      endcase
   end

   wire joined = (mac_st_r == ST_JOINED);
   // Force sense asserted for own transmit collision, or on the MAC's behalf
   wire cfs_req = tx_collision_i | (joined & ext_mac_tx_collision_i);
   wire lead = (lead_s == `LEAD_SELECT_VALUE);

   // Join sequence state and its window counter
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mac_st_r  <= ST_IDLE;
         win_cnt_r <= 8'h00;
      end else begin
         mac_st_r <= mac_st_nxt;
         // Reload only from idle, so a second pulse cannot stretch an open window
         if (mac_st_r == ST_IDLE && ext_mac_participate_i)
            win_cnt_r <= `PART_WINDOW_CYC;
         else if (win_cnt_r != 8'h00)
            win_cnt_r <= win_cnt_r - 8'h01;
      end
   end

   // Edge finder history; resets high like its synchroniser, so no false edge
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rclk_d_r <= 1'b1;
      end else begin
         rclk_d_r <= rclk_s;
      end
   end

   // Collision pins are open drain: the data bit stays low and only the enable moves
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         local_collision_n_o          <= 1'b0;
         local_collision_n_oe_n_o     <= `OE_N_RELEASED;
         backplane_collision_n_o      <= 1'b0;
         backplane_collision_n_oe_n_o <= `OE_N_RELEASED;
      end else begin
         local_collision_n_o          <= 1'b0;
         local_collision_n_oe_n_o     <= ~seg_collision_i;
         // Non-lead devices never touch the backplane copy
         backplane_collision_n_o      <= 1'b0;
         backplane_collision_n_oe_n_o <= ~(lead & seg_collision_i);
      end
   end

   // Force-sense pins; only a low is driven, the pull-up sets the resting level
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         collision_force_sense_o      <= 1'b0;
         collision_force_sense_oe_n_o <= `OE_N_RELEASED;
         backplane_force_sense_o      <= 1'b0;
         backplane_force_sense_oe_n_o <= `OE_N_RELEASED;
      end else begin
         collision_force_sense_o      <= 1'b0;
         collision_force_sense_oe_n_o <= ~cfs_req;
         // The backplane copy follows the on-board one, lead device only
         backplane_force_sense_o      <= 1'b0;
         backplane_force_sense_oe_n_o <= ~(lead & cfs_req);
      end
   end

   // Hold is a push-pull level owned by the lead device; others leave it alone
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         hold_collision_extend_o      <= `HOLD_RESET;
         hold_collision_extend_oe_n_o <= `OE_N_RELEASED;
      end else begin
         hold_collision_extend_oe_n_o <= ~lead;
         hold_collision_extend_o      <= lead & nonlocal_tx_collision_i;
      end
   end

   // Carrier enable: pulled low while the core has carrier, released when idle
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         backplane_carrier_n_o      <= 1'b0;
         backplane_carrier_n_oe_n_o <= `OE_N_RELEASED;
      end else begin
         backplane_carrier_n_o      <= 1'b0;
         backplane_carrier_n_oe_n_o <= ~core_carrier_i;
      end
   end

   // Status flags; far collision lags the shared pins by the synchroniser depth plus its own register
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mac_joined_o    <= 1'b0;
         far_collision_o <= 1'b0;
      end else begin
         mac_joined_o    <= joined;
         // Collision seen by others through the shared lines
         far_collision_o <= ~lcol_s | ~cfs_s;
      end
   end

   // Serial data: launch and capture on recovered clock rising edges; the enable is released at once when core carrier drops
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         backplane_serial_data_o      <= 1'b0;
         backplane_serial_data_oe_n_o <= `OE_N_RELEASED;
         rx_data_o                    <= `DATA_IDLE;
         rx_data_valid_o              <= 1'b0;
      end else begin
         rx_data_valid_o <= 1'b0;
         if (rclk_rise) begin
            // Open drain: only a zero is driven, a one is left to the pull-up
            backplane_serial_data_oe_n_o <= ~(core_carrier_i & ~core_tx_data_i);
            rx_data_o       <= rdata_s;
            rx_data_valid_o <= ~carrier_s;
         end else if (!core_carrier_i) begin
            backplane_serial_data_oe_n_o <= `OE_N_RELEASED;
         end
      end
   end

endmodule

// file: testbench/backplane_collision_checker.sv
// Concurrent checks on the collision signalling pins of the block.
// Assumes lead select only changes while all collision inputs are idle.
`timescale 1ns/1ps
module backplane_collision_checker (
   input wire ref_clk_i, rst_b_i, seg_collision_i, tx_collision_i, nonlocal_tx_collision_i, core_carrier_i,
   input wire board_lead_select_i, ext_mac_participate_i, ext_mac_tx_collision_i, backplane_carrier_n_i,
   input wire local_collision_n_oe_n_o, backplane_collision_n_oe_n_o, collision_force_sense_oe_n_o,
   input wire backplane_force_sense_oe_n_o, hold_collision_extend_o, hold_collision_extend_oe_n_o, mac_joined_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Lead device decoded once; the sync delay is covered by idle lead changes
   wire ld = !board_lead_select_i;
   a_local_pull: assert property (seg_collision_i |=> !local_collision_n_oe_n_o) else $error("local");
   a_bp_mirror: assert property (ld |-> backplane_collision_n_oe_n_o == local_collision_n_oe_n_o) else $error("bpcol");
   a_fs_pull: assert property (tx_collision_i |=> !collision_force_sense_oe_n_o) else $error("fs");
   a_bp_fs: assert property (ld ##1 ld && tx_collision_i |=> !backplane_force_sense_oe_n_o) else $error("bpfs");
   a_nonlead_free: assert property (board_lead_select_i[*5] |-> backplane_collision_n_oe_n_o
      && backplane_force_sense_oe_n_o && hold_collision_extend_oe_n_o) else $error("nonlead");
   a_hold_extend: assert property (ld && nonlocal_tx_collision_i |=> hold_collision_extend_o
      && !hold_collision_extend_oe_n_o) else $error("hold");
   // The joined flag trails the state by one cycle, so it is looked at one cycle on
   a_mac_fs: assert property (ext_mac_tx_collision_i ##1 mac_joined_o |-> !collision_force_sense_oe_n_o)
      else $error("macfs");
   // A carrier that this device drives itself does not count as the MAC joining
   a_join_seen: assert property ($rose(ext_mac_participate_i) ##1 (!backplane_carrier_n_i && !core_carrier_i)[*8]
      |-> mac_joined_o) else $error("join");
endmodule
bind backplane_collision backplane_collision_checker u_chk (.*);

// file: testbench/ext_mac_model.sv
// External MAC joining the backplane and sending one byte.
// Assumes the bench resolves the open-drain lines with pull-ups.
`timescale 1ns/1ps
module ext_mac_model (
   input  wire       clk_i, go_i, col_n_i,
   input  wire [7:0] bits_i,
   output reg        part_o = 1'b0, car_n_o = 1'b1, rclk_o = 1'b0, dat_o = 1'b1, col_seen_o = 1'b0
);
   integer i;
   // One frame per go; the link clock stands still outside frames
   always @(posedge go_i) begin
      @(negedge clk_i) part_o = 1'b1;
      @(negedge clk_i) part_o = 1'b0;
      car_n_o = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
         dat_o = bits_i[i]; // Settled well before the rise, so sampling is clean
         #40 rclk_o = 1'b1;
         #40 rclk_o = 1'b0;
      end
      car_n_o = 1'b1;
      dat_o = 1'b1;
   end
   // Collisions are learnt from the on-board line only
   always @(posedge clk_i)
      if (!car_n_o && !col_n_i) col_seen_o <= 1'b1;
endmodule

// file: testbench/test_backplane_collision.sv
// Self-checking bench for the backplane collision block.
// Assumes pins rest high through pull-ups unless someone drives them.
`timescale 1ns/1ps
module test_backplane_collision;
   logic ref_clk_i = 0, rst_b_i = 0, seg_collision_i = 0, tx_collision_i = 0, nonlocal_tx_collision_i = 0;
   logic board_lead_select_i = 0, ext_mac_tx_collision_i = 0, core_carrier_i = 0, core_tx_data_i = 1, go = 0;
   wire ext_mac_participate_i, local_collision_n_i, collision_force_sense_i, backplane_carrier_n_i;
   wire backplane_recovered_clock_i, backplane_serial_data_i, local_collision_n_o, local_collision_n_oe_n_o;
   wire backplane_collision_n_o, backplane_collision_n_oe_n_o, collision_force_sense_o, collision_force_sense_oe_n_o;
   wire backplane_force_sense_o, backplane_force_sense_oe_n_o, hold_collision_extend_o, hold_collision_extend_oe_n_o;
   wire backplane_carrier_n_o, backplane_carrier_n_oe_n_o, backplane_serial_data_o, backplane_serial_data_oe_n_o;
   wire rx_data_o, rx_data_valid_o, mac_joined_o, far_collision_o, mcar, mdat, cseen;
   integer error_cnt = 0, checks_done = 0, cyc = 0, rx_cnt = 0, n;
   logic [7:0] rx_sr = 8'h00;
   always #2.5 ref_clk_i = ~ref_clk_i;
   // Open-drain lines resolved from every party's enable
   assign local_collision_n_i = local_collision_n_oe_n_o | local_collision_n_o;
   assign collision_force_sense_i = collision_force_sense_oe_n_o | collision_force_sense_o;
   assign backplane_carrier_n_i = (backplane_carrier_n_oe_n_o | backplane_carrier_n_o) & mcar;
   assign backplane_serial_data_i = (backplane_serial_data_oe_n_o | backplane_serial_data_o) & mdat;
   backplane_collision DUT (.*);
   ext_mac_model mac (.clk_i(ref_clk_i), .go_i(go), .col_n_i(local_collision_n_i), .bits_i(8'ha5),
      .part_o(ext_mac_participate_i), .car_n_o(mcar), .rclk_o(backplane_recovered_clock_i),
      .dat_o(mdat), .col_seen_o(cseen));
   // Received bits, first bit ends up most significant
   always @(posedge ref_clk_i)
      if (rx_data_valid_o === 1'b1) begin
         rx_sr <= {rx_sr[6:0], rx_data_o};
         rx_cnt <= rx_cnt + 1;
      end
   task chk(input [7:0] seen, input [7:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task summarize;
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task cyc_n(input integer k);
      repeat (k) @(negedge ref_clk_i);
   endtask
   // All three collision causes at once, as lead and as non-lead
   task t_collision(input l);
      board_lead_select_i = l;
      cyc_n(6);
      {seg_collision_i, tx_collision_i, nonlocal_tx_collision_i} = 3'b111;
      cyc_n(2);
      chk({local_collision_n_i, collision_force_sense_i}, 0);
      chk({backplane_collision_n_oe_n_o, backplane_force_sense_oe_n_o}, {l, l});
      chk({hold_collision_extend_o, hold_collision_extend_oe_n_o}, {!l, l});
      cyc_n(3);
      chk(far_collision_o, 1);
      {seg_collision_i, tx_collision_i, nonlocal_tx_collision_i} = 3'b000;
      cyc_n(2);
      chk({local_collision_n_i, collision_force_sense_i, hold_collision_extend_o}, 3'b110);
      cyc_n(3);
      chk(far_collision_o, 0);
   endtask
   // MAC joins, collides mid-frame, and its byte is received
   task t_join;
      go = 1;
      for (n = 0; n < 20 && mac_joined_o !== 1'b1; n = n + 1) cyc_n(1);
      chk(mac_joined_o, 1);
      {ext_mac_tx_collision_i, seg_collision_i} = 2'b11;
      cyc_n(2);
      chk(collision_force_sense_oe_n_o, 0);
      {ext_mac_tx_collision_i, seg_collision_i} = 2'b00;
      for (n = 0; n < 300 && backplane_carrier_n_i !== 1'b1; n = n + 1) cyc_n(1);
      cyc_n(8);
      chk({mac_joined_o, cseen}, 2'b01);
      chk(rx_cnt, 8);
      chk(rx_sr, 8'ha5);
      go = 0;
   endtask
   // Own carrier pulls the shared line, release lets it rest high
   task t_carrier;
      core_carrier_i = 1;
      cyc_n(2);
      chk(backplane_carrier_n_i, 0);
      core_carrier_i = 0;
      cyc_n(2);
      chk(backplane_carrier_n_i, 1);
   endtask
   // Own carrier with a zero bit: data is pulled low from a recovered clock rise
   task t_drive;
      {core_carrier_i, core_tx_data_i, go} = 3'b101;
      for (n = 0; n < 300 && backplane_recovered_clock_i !== 1'b1; n = n + 1) cyc_n(1);
      cyc_n(6);
      chk({backplane_serial_data_oe_n_o, backplane_serial_data_i}, 2'b00);
      for (n = 0; n < 300 && mcar !== 1'b1; n = n + 1) cyc_n(1);
      {core_carrier_i, core_tx_data_i, go} = 3'b010;
      cyc_n(3);
      chk(backplane_serial_data_oe_n_o, 1);
   endtask
   always @(posedge ref_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         error_cnt = error_cnt + 1;
         summarize;
      end
   end
   initial begin
      cyc_n(16);
      rst_b_i = 1;
      cyc_n(4);
      chk({local_collision_n_i, collision_force_sense_i, backplane_carrier_n_i}, 3'b111);
      t_collision(1);
      t_collision(0);
      t_join;
      t_carrier;
      t_drive;
      summarize;
   end
endmodule
